// ### inc/bht_pkg.sv
// Purpose: constants and types for the bridge header tail registers
// Assumes: 32-bit register port, byte addresses on a word grid
// Notes:   fields of the buffering control word sit in its low byte
//
// Operation
// - rom base reads zero, writes ignored
// - routing byte read-write, resets to zero
// - pin byte 01h reverse, 00h forward
// - burst need byte read-only, reset zero
// - access interval byte read-only, reset zero
// - park bit picks last master or self
// - bit one disables prefetch dynamic control
// - bit two disables completion prediction
// - mode 00 one line, 10 full
// - mode 01 keeps data after bridge disconnect
// - mode 11 keeps data after any end
// - prefetch mode ignored in pcix mode
package bht_pkg;

  localparam logic [7:0]  BHT_OFS_ROM      = 8'h38;
  localparam logic [7:0]  BHT_OFS_INT      = 8'h3c;
  localparam logic [7:0]  BHT_OFS_BUF      = 8'h40;
  localparam logic [31:0] BHT_ROM_VALUE    = 32'h0000_0000;
  localparam logic [7:0]  BHT_ROUTE_RST    = 8'h00;
  localparam logic [7:0]  BHT_PIN_REVERSE  = 8'h01;
  localparam logic [7:0]  BHT_PIN_FORWARD  = 8'h00;
  localparam logic [7:0]  BHT_BURST_NEED   = 8'h00;
  localparam logic [7:0]  BHT_ACC_INTERVAL = 8'h00;
  localparam int          BHT_BIT_PARK     = 0;
  localparam int          BHT_BIT_DYN_DIS  = 1;
  localparam int          BHT_BIT_PRED_DIS = 2;
  localparam int          BHT_MODE_LO      = 4;
  localparam logic        BHT_PARK_RST     = 1'b0;
  localparam logic        BHT_DYN_DIS_RST  = 1'b0;
  localparam logic        BHT_PRED_DIS_RST = 1'b0;

  typedef enum logic [1:0] {
    BHT_PF_ONE_LINE  = 2'h0,
    BHT_PF_KEEP_DISC = 2'h1,
    BHT_PF_FULL      = 2'h2,
    BHT_PF_KEEP_ANY  = 2'h3
  } bht_pf_mode_t;

  // steering towards the secondary arbiter and read prefetch engine
  typedef struct packed {
    logic park_self;    // 1: park grant on own secondary port
    logic dyn_ctl_en;   // dynamic prefetch control active
    logic pred_en;      // completion data prediction active
    logic one_line;     // prefetch only one cache line
    logic full_pf;      // prefetch fully
    logic keep_on_disc; // keep leftovers after bridge disconnect
    logic keep_on_any;  // keep leftovers after either side ends
  } bht_ctl_t;

endpackage

// ### hdl/bht_regs.sv
// Purpose: expansion rom, interrupt and buffering control registers
// Assumes: strobes one cycle, never both; read data the cycle after
// Notes:   strap inputs are sampled every cycle, mode changes follow
//          one cycle later on the steering outputs; the pin byte
//          follows the strap live, so software that reads it while
//          the strap moves sees the new mode at once
//          the steering word is registered, so the datapath never
//          sees a half-decoded mode while software rewrites the field
`timescale 1ns/1ns
module bht_regs
  import bht_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        reverse_mode_i,
  input  wire logic        pcix_mode_i,
  output logic      [31:0] rdata_o,
  output bht_ctl_t         ctl_o
);

  logic [7:0]   route_r;
  logic         park_r;
  logic         dyn_dis_r;
  logic         pred_dis_r;
  bht_pf_mode_t pf_mode_r;
  logic [7:0]   pin_nxt;
  logic [31:0]  rdata_nxt;
  bht_ctl_t     ctl_nxt;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_r <= BHT_ROUTE_RST;
    end else if (wr_i && addr_i == BHT_OFS_INT) begin
      route_r <= wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      park_r <= BHT_PARK_RST;
    end else if (wr_i && addr_i == BHT_OFS_BUF) begin
      park_r <= wdata_i[BHT_BIT_PARK];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dyn_dis_r <= BHT_DYN_DIS_RST;
    end else if (wr_i && addr_i == BHT_OFS_BUF) begin
      dyn_dis_r <= wdata_i[BHT_BIT_DYN_DIS];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pred_dis_r <= BHT_PRED_DIS_RST;
    end else if (wr_i && addr_i == BHT_OFS_BUF) begin
      pred_dis_r <= wdata_i[BHT_BIT_PRED_DIS];
    end
  end

  // prefetch mode store, resets to full
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pf_mode_r <= BHT_PF_FULL;
    end else if (wr_i && addr_i == BHT_OFS_BUF) begin
      pf_mode_r <= bht_pf_mode_t'(wdata_i[BHT_MODE_LO+1:BHT_MODE_LO]);
    end
  end

  always_comb begin
    pin_nxt = reverse_mode_i ? BHT_PIN_REVERSE : BHT_PIN_FORWARD;
  end

  // read mux; unmapped offsets read zero so probing software sees nothing
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (addr_i)
      BHT_OFS_ROM: begin
        rdata_nxt = BHT_ROM_VALUE;
      end
      BHT_OFS_INT: begin
        rdata_nxt = {BHT_ACC_INTERVAL, BHT_BURST_NEED, pin_nxt, route_r};
      end
      BHT_OFS_BUF: begin
        rdata_nxt = {26'h000_0000, pf_mode_r, 1'b0, pred_dis_r,
                     dyn_dis_r, park_r};
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // read data lands one cycle after the strobe and only then
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // decode of steering outputs
  always_comb begin
    ctl_nxt = '0;
    ctl_nxt.park_self = park_r;
    ctl_nxt.dyn_ctl_en = !dyn_dis_r;
    ctl_nxt.pred_en = !pred_dis_r;
    // pcix overrides mode; all prefetch depth and keep outputs then stay clear
    if (!pcix_mode_i) begin
      case (pf_mode_r)
        BHT_PF_ONE_LINE: begin
          ctl_nxt.one_line = 1'b1;
        end
        BHT_PF_KEEP_DISC: begin
          ctl_nxt.full_pf      = 1'b1;
          ctl_nxt.keep_on_disc = 1'b1;
        end
        BHT_PF_KEEP_ANY: begin
          ctl_nxt.full_pf      = 1'b1;
          ctl_nxt.keep_on_disc = 1'b1;
          ctl_nxt.keep_on_any  = 1'b1;
        end
        default: begin
          ctl_nxt.full_pf = 1'b1;
        end
      endcase
    end
  end

  // registered so the datapath sees a clean flop output
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_o <= '0;
    end else begin
      ctl_o <= ctl_nxt;
    end
  end

  rom_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && addr_i == BHT_OFS_ROM |=> rdata_o == 32'h0000_0000)
    else $error("rom base read not zero");
  route_back_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && addr_i == BHT_OFS_INT ##1 rd_i && addr_i == BHT_OFS_INT
    |=> rdata_o[7:0] == $past(wdata_i[7:0], 2))
    else $error("routing byte lost");
  pin_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && addr_i == BHT_OFS_INT |=>
    rdata_o[15:8] == ($past(reverse_mode_i) ? BHT_PIN_REVERSE
                                             : BHT_PIN_FORWARD))
    else $error("pin byte wrong");
  timing_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && addr_i == BHT_OFS_INT |=> rdata_o[31:16] == 16'h0000)
    else $error("timing bytes not zero");
  park_ctl_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && addr_i == BHT_OFS_BUF ##1 !wr_i
    |=> ctl_o.park_self == $past(wdata_i[0], 2))
    else $error("park select not applied");
  enables_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(rst_b_i) |->
    ctl_o.dyn_ctl_en == !$past(dyn_dis_r) &&
    ctl_o.pred_en == !$past(pred_dis_r))
    else $error("enable polarity wrong");
  pcix_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    pcix_mode_i |=> !ctl_o.one_line && !ctl_o.full_pf &&
    !ctl_o.keep_on_disc && !ctl_o.keep_on_any)
    else $error("prefetch mode used in pcix");
  keep_any_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !pcix_mode_i && pf_mode_r == BHT_PF_KEEP_ANY |=>
    ctl_o.keep_on_any && ctl_o.full_pf)
    else $error("keep-any mode not decoded");
  keep_disc_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !pcix_mode_i && pf_mode_r == BHT_PF_KEEP_DISC |=>
    ctl_o.keep_on_disc && !ctl_o.keep_on_any)
    else $error("keep-disconnect mode wrong");
  one_line_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !pcix_mode_i && pf_mode_r == BHT_PF_ONE_LINE |=>
    ctl_o.one_line && !ctl_o.full_pf)
    else $error("one-line mode wrong");

  // read data stands one cycle only, so stale words never linger
  rdata_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data outlived its cycle");

  // unmapped offsets read zero
  unmapped_zero_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i)
    rd_i && addr_i != BHT_OFS_ROM && addr_i != BHT_OFS_INT &&
    addr_i != BHT_OFS_BUF |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // first edge after reset shows cleared read data
  rdata_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !$past(rst_b_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data not clear after reset");

  // spare bits of the buffering word read zero
  buf_spare_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && addr_i == BHT_OFS_BUF |=>
    rdata_o[31:6] == 26'h000_0000 && !rdata_o[3])
    else $error("spare buffering bits set");

  // mode field written then read back at once
  buf_back_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && addr_i == BHT_OFS_BUF ##1 rd_i && addr_i == BHT_OFS_BUF
    |=> rdata_o[5:4] == $past(wdata_i[5:4], 2))
    else $error("prefetch mode lost");

  // low control bits written then read back at once
  buf_low_back_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i)
    wr_i && addr_i == BHT_OFS_BUF ##1 rd_i && addr_i == BHT_OFS_BUF
    |=> rdata_o[2:0] == $past(wdata_i[2:0], 2))
    else $error("buffering bits lost");

  // timing bytes ignore writes
  ro_bytes_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && addr_i == BHT_OFS_INT ##1 rd_i && addr_i == BHT_OFS_INT
    |=> rdata_o[31:16] == {BHT_ACC_INTERVAL, BHT_BURST_NEED})
    else $error("read-only timing bytes took a write");

  // routing byte read shows the stored value
  int_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && addr_i == BHT_OFS_INT |=> rdata_o[7:0] == $past(route_r))
    else $error("routing byte read wrong");

  // mode field read shows the stored value
  buf_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && addr_i == BHT_OFS_BUF |=> rdata_o[5:4] == $past(pf_mode_r))
    else $error("prefetch mode read wrong");

  // low control bits read shows the stored values
  buf_bits_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && addr_i == BHT_OFS_BUF |=>
    rdata_o[2:0] == {$past(pred_dis_r), $past(dyn_dis_r), $past(park_r)})
    else $error("buffering bits read wrong");

  // routing byte only moves on its own write
  route_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !(wr_i && addr_i == BHT_OFS_INT) |=> route_r == $past(route_r))
    else $error("routing byte changed unasked");

  // prefetch mode only moves on its own write
  mode_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !(wr_i && addr_i == BHT_OFS_BUF) |=> pf_mode_r == $past(pf_mode_r))
    else $error("prefetch mode changed unasked");

  // prediction enable follows a write
  pred_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && addr_i == BHT_OFS_BUF ##1 !wr_i
    |=> ctl_o.pred_en == !$past(wdata_i[2], 2))
    else $error("prediction enable not applied");

  // dynamic control enable follows a write
  dyn_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && addr_i == BHT_OFS_BUF ##1 !wr_i
    |=> ctl_o.dyn_ctl_en == !$past(wdata_i[1], 2))
    else $error("dynamic control not applied");

  // full mode, the reset choice; skipped on the first edge after reset
  full_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(rst_b_i) && !pcix_mode_i && pf_mode_r == BHT_PF_FULL |=>
    ctl_o.full_pf && !ctl_o.one_line && !ctl_o.keep_on_disc &&
    !ctl_o.keep_on_any)
    else $error("full mode wrong");

  // pcix mode leaves the park choice alone
  pcix_park_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    pcix_mode_i |=> ctl_o.park_self == $past(park_r))
    else $error("park lost in pcix mode");

  // steering is clear on the first edge after reset
  ctl_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !$past(rst_b_i) |-> ctl_o == '0)
    else $error("steering not clear after reset");

  // keep-after-disconnect still prefetches fully
  keep_disc_full_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i)
    !pcix_mode_i && pf_mode_r == BHT_PF_KEEP_DISC |=>
    ctl_o.full_pf && !ctl_o.one_line)
    else $error("keep-disconnect not full");

  // keep-any also keeps after a bridge disconnect
  keep_any_disc_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i)
    !pcix_mode_i && pf_mode_r == BHT_PF_KEEP_ANY |=>
    ctl_o.keep_on_disc && !ctl_o.one_line)
    else $error("keep-any misses disconnect");

  // one-line mode keeps nothing behind
  one_line_keep_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i)
    !pcix_mode_i && pf_mode_r == BHT_PF_ONE_LINE |=>
    !ctl_o.keep_on_disc && !ctl_o.keep_on_any)
    else $error("one-line mode keeps data");

  // conventional mode picks exactly one prefetch depth
  conv_one_hot_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i)
    $past(rst_b_i) && !pcix_mode_i |=> ctl_o.one_line != ctl_o.full_pf)
    else $error("prefetch depth ambiguous");

endmodule

// ### tb/tb_bht_regs.sv
// Purpose: self-checking bench for the header tail registers
// Assumes: 100 MHz clock, read data stands one cycle after the strobe
// Notes:   reads queue their expectation, a watcher pops and compares
`timescale 1ns/1ns
module tb_bht_regs
  import bht_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        rev       = 1'b0;
  logic        pcix      = 1'b0;
  logic        rd_d      = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic [31:0] wd;
  logic [31:0] rdata;
  bht_ctl_t    ctl;
  int          miscompares  = 0;
  int          total_checks = 0;
  logic [31:0] exp_q[$];

  bht_regs bht_regs_inst (
    .clk_sys_i      (clk_sys_i),
    .rst_b_i        (rst_b_i),
    .addr_i         (addr),
    .wdata_i        (wdata),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .reverse_mode_i (rev),
    .pcix_mode_i    (pcix),
    .rdata_o        (rdata),
    .ctl_o          (ctl)
  );

  // free-running system clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // expected steering, worked out from the written word and bus mode
  function automatic bht_ctl_t exp_ctl(logic [31:0] w, logic px);
    bht_ctl_t c;
    c.park_self    = w[0];
    c.dyn_ctl_en   = ~w[1];
    c.pred_en      = ~w[2];
    c.one_line     = ~px & (w[5:4] == 2'h0);
    c.full_pf      = ~px & (w[5:4] != 2'h0);
    c.keep_on_disc = ~px & w[4];
    c.keep_on_any  = ~px & (w[5:4] == 2'h3);
    return c;
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp, string msg);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // one bus cycle; strobes of back-to-back calls simply replace each other
  task automatic op(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    @(posedge clk_sys_i);
    wr_i  <= w;
    rd_i  <= ~w;
    addr  <= a;
    wdata <= d;
    if (!w)
      exp_q.push_back(e);
  endtask

  task automatic idle;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask

  // steering lags the register by one cycle, so let two edges pass
  task automatic ctl_chk(bht_ctl_t e);
    idle;
    repeat (2) @(posedge clk_sys_i);
    #1 check({25'h0, ctl}, {25'h0, e}, "steering");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watcher: read data is only valid in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (rd_d && exp_q.size() > 0)
      check(rdata, exp_q.pop_front(), "read data");
    rd_d <= rd_i & rst_b_i;
  end

  // hang guard, far beyond the length of the sequence
  initial begin
    #200000;
    miscompares++;
    results;
  end

  initial begin
    void'($urandom(65));
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    // reset values in forward and then reverse mode
    for (int r = 0; r < 2; r++) begin
      rev <= r[0];
      op(1'b0, 8'h38, 32'h0, 32'h0);
      op(1'b0, 8'h3c, 32'h0, {16'h0, 7'h0, r[0], 8'h00});
      op(1'b0, 8'h40, 32'h0, 32'h20);
      ctl_chk(exp_ctl(32'h20, 1'b0));
    end
    $display("test reset values done");
    // read-only places and an unmapped word ignore writes
    for (int i = 0; i < 4; i++) begin
      wd = $urandom;
      op(1'b1, 8'h38, wd, 32'h0);
      op(1'b1, 8'h3c, wd, 32'h0);
      op(1'b1, 8'h44, wd, 32'h0);
      op(1'b0, 8'h38, 32'h0, 32'h0);
      op(1'b0, 8'h3c, 32'h0, {16'h0, 7'h0, rev, wd[7:0]});
      op(1'b0, 8'h44, 32'h0, 32'h0);
      op(1'b1, 8'h3c, ~wd, 32'h0);
      op(1'b0, 8'h3c, 32'h0, {16'h0, 7'h0, rev, ~wd[7:0]});
    end
    idle;
    $display("test interrupt word done");
    // every prefetch mode, with the bus in both modes
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wd      = $urandom;
        wd[5:4] = m[1:0];
        pcix   <= p[0];
        op(1'b1, 8'h40, wd, 32'h0);
        op(1'b0, 8'h40, 32'h0, wd & 32'h37);
        ctl_chk(exp_ctl(wd, p[0]));
      end
    end
    $display("test buffering control done");
    // a second reset in mid-run brings back the defaults
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    pcix    <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    op(1'b0, 8'h40, 32'h0, 32'h20);
    op(1'b0, 8'h3c, 32'h0, {16'h0, 7'h0, rev, 8'h00});
    ctl_chk(exp_ctl(32'h20, 1'b0));
    $display("test second reset done");
    repeat (4) @(posedge clk_sys_i);
    if (exp_q.size() != 0)
      miscompares++;
    results;
  end
endmodule
